/* hw/uis_pkg.sv */
package uis_pkg;

	// source indices, lowest index wins
	localparam int UIS_NUM_SRC = 7;
	localparam int UIS_SRC_W = 3;
	localparam int UIS_SRC_LSR = 0;
	localparam int UIS_SRC_RXDATA = 1;
	localparam int UIS_SRC_RXTO = 2;
	localparam int UIS_SRC_THR = 3;
	localparam int UIS_SRC_MSR = 4;
	localparam int UIS_SRC_XOFF = 5;
	localparam int UIS_SRC_FLOW = 6;

	// register byte offsets
	localparam logic [7:0] UIS_OFF_ISR = 8'h00;
	localparam logic [7:0] UIS_OFF_FCR = 8'h04;
	localparam logic [7:0] UIS_OFF_EFR = 8'h08;

	// field positions
	localparam int UIS_FCR_EN_BIT = 0;
	localparam int UIS_EFR_ENH_BIT = 4;
	localparam int UIS_ISR_STAT_BIT = 0;
	localparam int UIS_ISR_FIFO_LSB = 6;

	// reset values
	localparam logic UIS_FIFO_EN_RST = 1'b0;
	localparam logic [7:0] UIS_EFR_RST = 8'h00;
	localparam logic [5:0] UIS_CODE_NONE = 6'h01;

	// status codes, bits 5..0, index 0 at the right
	localparam logic [6:0][5:0] UIS_CODE = {
		6'h20, 6'h10, 6'h00, 6'h02, 6'h0c, 6'h04, 6'h06
	};

	// priority level of each source
	localparam logic [6:0][2:0] UIS_LEVEL = {
		3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1
	};
	localparam logic [2:0] UIS_LEVEL_MIN = 3'h1;
	localparam logic [2:0] UIS_LEVEL_MAX = 3'h6;

	typedef enum logic [1:0] {
		UIS_ST_IDLE = 2'b01,
		UIS_ST_HELD = 2'b10
	} uis_state_t;

endpackage

/* hw/uis_prio_enc.sv */
`timescale 1ns/1ps
module uis_prio_enc #(
	parameter int N = 7,
	parameter int IW = 3
) (
	input wire logic [N-1:0] i_pend,
	output logic o_any,
	output logic [IW-1:0] o_idx
);

	// lowest pending index wins
	always_comb begin
		o_any = |i_pend;
		o_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_pend[i]) begin
				o_idx = IW'(i);
			end
		end
	end

endmodule // uis_prio_enc

/* hw/uis_flag.sv */
`timescale 1ns/1ps
module uis_flag #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	output logic [W-1:0] o_flag
);

	// sticky flags, a set beats a clear in the same cycle
	for (genvar g = 0; g < W; g++) begin : g_flag
		logic flag_r;
		logic flag_nxt;
		assign flag_nxt = i_set[g] | (flag_r & ~i_clr[g]);
		always_ff @(posedge i_clk or posedge i_rst) begin
			if (i_rst) begin
				flag_r <= 1'b0;
			end else begin
				flag_r <= flag_nxt;
			end
		end
		assign o_flag[g] = flag_r;
	end

endmodule // uis_flag

/* hw/uis_top.sv */
// Functional notes
// - sources rank into six levels, level 1 most urgent, level 6 least
// - reading the status register returns the held source code, the highest pending one when it was latched
// - reported source held until serviced; host re-reads to see lower ones
// - line status: level 1, bits 5..0 read 000110
// - receive data available: level 2, bits 5..0 read 000100
// - receive time-out: level 2, bits 5..0 read 001100
// - bits 3..1 name levels 1 to 3; holding empty: level 3, 000010
// - xoff or special character: level 5, only bit 4 set
// - cts or rts change: level 6, only bit 5 set
// - bits 7..6 read 11 with fifos enabled, else 00, 00 at reset
// - bits 5..4 report only while enhanced bit 4 is set
// - xoff indication stays set until xon characters arrive
// - bit 0 low while pending, high when idle and at reset
// - fifo control bit 0 written 1 enables fifos, 0 disables them
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module uis_top #(
	parameter int AW = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_line_status_evt,
	input wire logic i_rx_data_ready,
	input wire logic i_rx_timeout,
	input wire logic i_thr_empty,
	input wire logic i_modem_status_evt,
	input wire logic i_xoff_detect,
	input wire logic i_xon_received,
	input wire logic i_special_char,
	input wire logic i_flow_change,
	output logic o_int_pending,
	output logic o_fifo_enabled
);

	logic fifo_en_r;
	logic fifo_en_nxt;
	logic [7:0] efr_r;
	logic [7:0] efr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic slverr_r;
	logic slverr_nxt;
	uis_pkg::uis_state_t state_r;
	uis_pkg::uis_state_t state_nxt;
	logic [uis_pkg::UIS_SRC_W-1:0] src_r;
	logic [uis_pkg::UIS_SRC_W-1:0] src_nxt;

	// bus phase decode
	wire setup_ph = i_psel & ~i_penable;
	wire access_ph = i_psel & i_penable;
	wire wr_take = access_ph & i_pwrite & i_pstrb[0];
	wire hit_isr = i_paddr == AW'(uis_pkg::UIS_OFF_ISR);
	wire hit_fcr = i_paddr == AW'(uis_pkg::UIS_OFF_FCR);
	wire hit_efr = i_paddr == AW'(uis_pkg::UIS_OFF_EFR);
	wire hit_any = hit_isr | hit_fcr | hit_efr;
	wire bad_req = ~hit_any | (i_pwrite & hit_isr);
	wire fcr_wr = wr_take & hit_fcr;
	wire efr_wr = wr_take & hit_efr;
	wire enh_on = efr_r[uis_pkg::UIS_EFR_ENH_BIT];

	// xoff indication latch, cleared by xon
	wire xoff_set = i_xoff_detect & enh_on;
	wire xoff_flag;
	uis_flag #(
		.W(1)
	) u_xoff (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(xoff_set),
		.i_clr(i_xon_received),
		.o_flag(xoff_flag)
	);

	// pending sources, enhanced ones gated
	wire [uis_pkg::UIS_NUM_SRC-1:0] pend;
	assign pend[uis_pkg::UIS_SRC_LSR] = i_line_status_evt;
	assign pend[uis_pkg::UIS_SRC_RXDATA] = i_rx_data_ready;
	assign pend[uis_pkg::UIS_SRC_RXTO] = i_rx_timeout;
	assign pend[uis_pkg::UIS_SRC_THR] = i_thr_empty;
	assign pend[uis_pkg::UIS_SRC_MSR] = i_modem_status_evt;
	assign pend[uis_pkg::UIS_SRC_XOFF] =
		enh_on & (xoff_flag | i_special_char);
	assign pend[uis_pkg::UIS_SRC_FLOW] = enh_on & i_flow_change;

	// pick the most urgent source
	wire enc_any;
	wire [uis_pkg::UIS_SRC_W-1:0] enc_idx;
	uis_prio_enc #(
		.N(uis_pkg::UIS_NUM_SRC),
		.IW(uis_pkg::UIS_SRC_W)
	) u_enc (
		.i_pend(pend),
		.o_any(enc_any),
		.o_idx(enc_idx)
	);

	// hold the reported source until its condition is serviced
	wire held = state_r == uis_pkg::UIS_ST_HELD;
	wire held_live = held & pend[src_r];
	// enhanced sources hidden while enhanced mode is off
	wire held_enh = src_r >= 3'(uis_pkg::UIS_SRC_XOFF);
	wire held_vis = held & (enh_on | ~held_enh);
	always_comb begin
		state_nxt = state_r;
		src_nxt = src_r;
		case (state_r)
			uis_pkg::UIS_ST_IDLE: begin
				if (enc_any) begin
					state_nxt = uis_pkg::UIS_ST_HELD;
					src_nxt = enc_idx;
				end
			end
			uis_pkg::UIS_ST_HELD: begin
				if (!pend[src_r]) begin
					state_nxt = enc_any ? uis_pkg::UIS_ST_HELD :
						uis_pkg::UIS_ST_IDLE;
					src_nxt = enc_any ? enc_idx : src_r;
				end
			end
			default: begin
				state_nxt = uis_pkg::UIS_ST_IDLE;
				src_nxt = '0;
			end
		endcase
	end

	// status register contents
	wire [5:0] code = held_vis ? uis_pkg::UIS_CODE[src_r] :
		uis_pkg::UIS_CODE_NONE;
	wire [1:0] fifo_bits = {2{fifo_en_r}};
	wire [7:0] isr_val = {fifo_bits, code};
	wire [2:0] held_lvl = uis_pkg::UIS_LEVEL[src_r];

	// read mux for the setup cycle
	wire [7:0] rd_byte = hit_isr ? isr_val :
		hit_fcr ? {7'h00, fifo_en_r} :
		hit_efr ? efr_r : 8'h00;

	// next values of the software registers
	assign fifo_en_nxt = fcr_wr ?
		i_pwdata[uis_pkg::UIS_FCR_EN_BIT] : fifo_en_r;
	assign efr_nxt = efr_wr ? i_pwdata[7:0] : efr_r;
	assign prdata_nxt = (setup_ph & ~i_pwrite) ? {24'h000000, rd_byte} :
		prdata_r;
	assign slverr_nxt = setup_ph ? bad_req : slverr_r;

	// register file and report state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fifo_en_r <= uis_pkg::UIS_FIFO_EN_RST;
			efr_r <= uis_pkg::UIS_EFR_RST;
			prdata_r <= 32'h00000000;
			slverr_r <= 1'b0;
			state_r <= uis_pkg::UIS_ST_IDLE;
			src_r <= '0;
		end else begin
			fifo_en_r <= fifo_en_nxt;
			efr_r <= efr_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
			state_r <= state_nxt;
			src_r <= src_nxt;
		end
	end

	// bus answers in the first access cycle
	assign o_pready = access_ph;
	assign o_pslverr = access_ph & slverr_r;
	assign o_prdata = prdata_r;
	assign o_int_pending = held_vis;
	assign o_fifo_enabled = fifo_en_r;

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	chk_bit0_status: assert property (
		isr_val[uis_pkg::UIS_ISR_STAT_BIT] == !o_int_pending
	) else $error("status bit 0 disagrees with pending state");

	chk_held_source: assert property (
		held_live |=> held && src_r == $past(src_r)
	) else $error("reported source changed before service");

	chk_level_range: assert property (
		held |-> held_lvl >= uis_pkg::UIS_LEVEL_MIN &&
			held_lvl <= uis_pkg::UIS_LEVEL_MAX
	) else $error("held level outside one to six");

	chk_fifo_bits: assert property (
		isr_val[7:uis_pkg::UIS_ISR_FIFO_LSB] == {2{o_fifo_enabled}}
	) else $error("fifo bits do not follow fifo enable");

	chk_fcr_write: assert property (
		fcr_wr |=> o_fifo_enabled ==
			$past(i_pwdata[uis_pkg::UIS_FCR_EN_BIT])
	) else $error("fifo enable did not take the written bit");

	chk_enh_gate: assert property (
		!enh_on |-> isr_val[5:4] == 2'b00
	) else $error("enhanced bits set while enhanced mode off");

	chk_xoff_stays: assert property (
		xoff_flag && !i_xon_received |=> xoff_flag [*1]
	) else $error("xoff indication dropped without xon");

	chk_xoff_sets: assert property (
		xoff_set |=> xoff_flag
	) else $error("xoff detection not latched");

	chk_lsr_code: assert property (
		!held && pend[uis_pkg::UIS_SRC_LSR] |=> isr_val[5:0] == 6'h06
	) else $error("line status code wrong");

	chk_rxdata_code: assert property (
		!held && pend[1:0] == 2'b10 |=> isr_val[5:0] == 6'h04
	) else $error("receive data code wrong");

	chk_rxto_code: assert property (
		!held && pend[2:0] == 3'b100 |=> isr_val[5:0] == 6'h0c
	) else $error("receive time-out code wrong");

	chk_thr_code: assert property (
		!held && pend[3:0] == 4'b1000 |=> isr_val[5:0] == 6'h02
	) else $error("holding empty code wrong");

	chk_msr_code: assert property (
		!held && pend[4:0] == 5'b10000 |=> isr_val[5:0] == 6'h00
	) else $error("modem status code wrong");

	chk_xoff_code: assert property (
		!held && pend[5:0] == 6'b100000 |=> isr_val[5:0] == 6'h10
	) else $error("xoff or special character code wrong");

	chk_flow_code: assert property (
		!held && pend == 7'b1000000 |=> isr_val[5:0] == 6'h20
	) else $error("flow change code wrong");

	chk_read_value: assert property (
		setup_ph && !i_pwrite && hit_isr |=>
			o_prdata[7:0] == $past(isr_val) && o_prdata[31:8] == 24'h0
	) else $error("status read returned wrong value");

	chk_release: assert property (
		held && !pend[src_r] && !enc_any |=> !held ##1 1'b1
	) else $error("serviced source not released");

	chk_unmapped: assert property (
		setup_ph && !hit_any |=> o_pslverr || !access_ph
	) else $error("unmapped access not flagged");

	chk_enc_lowest: assert property (
		enc_any |-> pend[enc_idx] &&
			(pend & ((7'h01 << enc_idx) - 7'h01)) == 7'h00
	) else $error("encoder did not pick the most urgent source");

	chk_latch_idle: assert property (
		!held && enc_any |=> held && src_r == $past(enc_idx)
	) else $error("pending source not latched from idle");

	chk_direct_next: assert property (
		held && !pend[src_r] && enc_any |=>
			held && src_r == $past(enc_idx)
	) else $error("next source not taken after service");

	chk_stay_idle: assert property (
		!held && !enc_any |=> !held
	) else $error("report raised with nothing pending");

	chk_xon_clears: assert property (
		i_xon_received && !xoff_set |=> !xoff_flag
	) else $error("xon did not clear the xoff indication");

	chk_xoff_gated: assert property (
		!enh_on && !xoff_flag |=> !xoff_flag
	) else $error("xoff latched while enhanced mode off");

	chk_efr_write: assert property (
		efr_wr |=> efr_r == $past(i_pwdata[7:0])
	) else $error("enhanced register did not take the write");

	chk_fcr_keep: assert property (
		access_ph && i_pwrite && !hit_fcr |=> $stable(fifo_en_r)
	) else $error("fifo enable changed by another write");

	chk_fcr_read: assert property (
		setup_ph && !i_pwrite && hit_fcr |=>
			o_prdata == {31'h00000000, $past(fifo_en_r)}
	) else $error("fifo control readback wrong");

	chk_bad_read: assert property (
		setup_ph && !i_pwrite && !hit_any |=>
			o_prdata == 32'h00000000
	) else $error("unmapped read returned data");

	chk_isr_write: assert property (
		access_ph && i_pwrite && hit_isr |-> o_pslverr
	) else $error("write to status register not refused");

	chk_pready_access: assert property (
		o_pready == (i_psel && i_penable)
	) else $error("ready not given in the access cycle");

	chk_slverr_idle: assert property (
		!access_ph |-> !o_pslverr
	) else $error("error flagged outside the access cycle");

	chk_enh_hidden: assert property (
		held && src_r >= 3'(uis_pkg::UIS_SRC_XOFF) && !enh_on |->
			!o_int_pending
	) else $error("enhanced source shown while enhanced mode off");

	cov_lsr_held: cover property (
		held && src_r == uis_pkg::UIS_SRC_LSR
	);

	cov_flow_held: cover property (
		held && src_r == uis_pkg::UIS_SRC_FLOW
	);

	cov_masked_higher: cover property (
		held_live && enc_idx < src_r
	);

	cov_isr_read: cover property (
		access_ph && !i_pwrite && hit_isr && o_prdata[0] == 1'b0
	);

	cov_xoff_held: cover property (
		held && src_r == uis_pkg::UIS_SRC_XOFF && xoff_flag
	);

endmodule // uis_top

/* sim/uis_host.sv */
`timescale 1ns/1ps
module uis_host (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_wr,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic o_done,
	output logic [31:0] o_rdata,
	output logic o_err
);
	// setup on go, access next, release only at the pready edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_psel <= 1'b0;
			o_penable <= 1'b0;
			o_pwrite <= 1'b0;
			o_paddr <= 8'h00;
			o_pwdata <= 32'h0;
			o_done <= 1'b0;
			o_rdata <= 32'h0;
			o_err <= 1'b0;
		end else if (o_psel && o_penable && i_pready) begin
			o_psel <= 1'b0;
			o_penable <= 1'b0;
			o_paddr <= ~o_paddr; // released address and data lines do not keep old value
			o_pwdata <= ~o_pwdata;
			o_rdata <= i_prdata;
			o_err <= i_pslverr;
			o_done <= 1'b1;
		end else if (o_psel) begin
			o_penable <= 1'b1;
		end else if (i_go) begin
			o_psel <= 1'b1;
			o_pwrite <= i_wr;
			o_paddr <= i_addr;
			o_pwdata <= i_wdata;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
		end
	end
endmodule // uis_host

/* sim/uart_interrupt_priority_status_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module uart_interrupt_priority_status_test;
	logic i_clk = 1'b0;
	logic i_rst = 1'b0;
	logic go = 1'b0;
	logic wr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [6:0] src = 7'h00;
	logic xoff_det = 1'b0;
	logic xon = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, done, berr, pend, fen, fe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata, w;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	// expected bits 5..0 per source, most urgent last, at index 0
	localparam logic [6:0][5:0] CODE = {
		6'h20,
		6'h10,
		6'h00,
		6'h02,
		6'h0c,
		6'h04,
		6'h06
	};
	uis_top #(.AW(8)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(4'h1), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_line_status_evt(src[0]), .i_rx_data_ready(src[1]),
		.i_rx_timeout(src[2]), .i_thr_empty(src[3]),
		.i_modem_status_evt(src[4]), .i_xoff_detect(xoff_det),
		.i_xon_received(xon), .i_special_char(src[5]),
		.i_flow_change(src[6]), .o_int_pending(pend),
		.o_fifo_enabled(fen));
	uis_host host (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_wr(wr),
		.i_addr(addr), .i_wdata(wdata), .i_pready(pready),
		.i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata), .o_done(done), .o_rdata(rdata), .o_err(berr));
	// clock and hang guard
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			conclude();
		end
	end
	function automatic logic [7:0] exp_isr(input logic f, input logic [5:0] c);
		return {f, f, c};
	endfunction
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one apb transfer through the host model, returns after an edge
	task automatic bus(input logic w_, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		go <= 1'b1;
		wr <= w_;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		go <= 1'b0;
		do begin
			@(negedge i_clk);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (done !== 1'b1) err_total++; // hang is a mismatch
		@(posedge i_clk);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	initial begin
		void'($urandom(32'h479c973b));
		i_rst <= 1'b1;
		tick(10);
		i_rst <= 1'b0;
		tick(1);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata, 32'h00000001)
		`CHK(pend, 1'b0)
		bus(1'b0, 8'h04, 32'h0); `CHK(rdata[7:0], 8'h00)
		bus(1'b0, 8'h0c, 32'h0); `CHK(berr, 1'b1)
		bus(1'b1, 8'h00, 32'h0); `CHK(berr, 1'b1)
		// enhanced bit clear hides levels 5 and 6
		src <= 7'h60;
		tick(2);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[7:0], 8'h01)
		src <= 7'h00;
		w = $urandom;
		bus(1'b1, 8'h08, {24'h0, w[7:0] | 8'h10});
		bus(1'b0, 8'h08, 32'h0); `CHK(rdata[7:0], w[7:0] | 8'h10)
		// all sources at once, serviced one by one
		for (int r = 0; r < 3; r++) begin
			w = $urandom;
			if (r < 2) w[0] = r[0]; // both fifo settings at least once
			fe = w[0];
			bus(1'b1, 8'h04, w);
			`CHK(fen, fe)
			src <= 7'h7f;
			tick(2);
			for (int k = 0; k < 7; k++) begin
				bus(1'b0, 8'h00, 32'h0);
				`CHK(rdata[7:0], exp_isr(fe, CODE[k]))
				`CHK(pend, 1'b1)
				src[k] <= 1'b0;
				tick(2);
			end
			bus(1'b0, 8'h00, 32'h0); `CHK(rdata[7:0], exp_isr(fe, 6'h01))
		end
		// lower source held while a more urgent one arrives
		src[3] <= 1'b1;
		tick(2);
		src[0] <= 1'b1;
		tick(2);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[5:0], 6'h02)
		src[3] <= 1'b0;
		tick(2);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[5:0], 6'h06)
		src[0] <= 1'b0;
		tick(2);
		// xoff indication sticks until xon
		xoff_det <= 1'b1;
		tick(1);
		xoff_det <= 1'b0;
		tick(4);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[5:0], 6'h10)
		xon <= 1'b1;
		tick(1);
		xon <= 1'b0;
		tick(2);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[5:0], 6'h01)
		// mid-run reset drops fifo and enhanced settings
		bus(1'b1, 8'h04, 32'h1);
		i_rst <= 1'b1;
		tick(2);
		i_rst <= 1'b0;
		tick(1);
		`CHK(fen, 1'b0)
		`CHK(pend, 1'b0)
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata, 32'h00000001)
		// xoff seen with enhanced mode off must not latch
		xoff_det <= 1'b1;
		tick(1);
		xoff_det <= 1'b0;
		bus(1'b1, 8'h08, 32'h10);
		tick(2);
		bus(1'b0, 8'h00, 32'h0); `CHK(rdata[7:0], 8'h01)
		conclude();
	end
endmodule // uart_interrupt_priority_status_test
